/* jtp_pkg.sv */
/*
  Shared constants and types for the test access port and its controller.
  Assumes both ends compile against this package; nothing is imported.
*/
package jtp_pkg;

  // Controller states, standard sixteen-state coding
  typedef enum logic [3:0] {
    JTP_TLR      = 4'hF,
    JTP_RTI      = 4'hC,
    JTP_SEL_DR   = 4'h7,
    JTP_CAP_DR   = 4'h6,
    JTP_SHIFT_DR = 4'h2,
    JTP_EX1_DR   = 4'h1,
    JTP_PAUSE_DR = 4'h3,
    JTP_EX2_DR   = 4'h0,
    JTP_UPD_DR   = 4'h5,
    JTP_SEL_IR   = 4'h4,
    JTP_CAP_IR   = 4'hE,
    JTP_SHIFT_IR = 4'hA,
    JTP_EX1_IR   = 4'h9,
    JTP_PAUSE_IR = 4'hB,
    JTP_EX2_IR   = 4'h8,
    JTP_UPD_IR   = 4'hD
  } jtp_state_t;

  // Instruction register layout
  localparam int          JTP_IR_W       = 4;
  localparam logic [3:0]  JTP_IR_CAPTURE = 4'h1;
  localparam logic [3:0]  JTP_INS_IDCODE = 4'h1;
  localparam logic [3:0]  JTP_INS_BYPASS = 4'hF;

  // Identification register; value is arbitrary
  localparam int          JTP_ID_W       = 32;
  localparam logic [31:0] JTP_ID_VALUE   = 32'h1234_5AB1;

  // Consecutive high mode-select clocks that force reset
  localparam logic [2:0]  JTP_TMS_RESET_CNT = 3'h5;

  // Controller clocking: system clock 40 MHz, link half period in ns
  localparam int          JTP_CLK_NS     = 25;
  localparam int          JTP_TCK_HALF_NS = 100;
  localparam logic [3:0]  JTP_TCK_HALF_CYC =
    4'((JTP_TCK_HALF_NS + JTP_CLK_NS - 1) / JTP_CLK_NS);
  // Test reset pulse width driven by the controller
  localparam int          JTP_TRST_NS    = 200;
  localparam logic [3:0]  JTP_TRST_CYC   =
    4'((JTP_TRST_NS + JTP_CLK_NS - 1) / JTP_CLK_NS);

  // Controller command set
  typedef enum logic [1:0] {
    JTP_CMD_TMS_RESET  = 2'h0,
    JTP_CMD_TRST_RESET = 2'h1,
    JTP_CMD_SHIFT_IR   = 2'h2,
    JTP_CMD_SHIFT_DR   = 2'h3
  } jtp_cmd_t;

  // Mode-select walks, sent least significant bit first
  localparam logic [5:0]  JTP_PRE_TMS_RST  = 6'h1F;  // 1,1,1,1,1,0
  localparam logic [2:0]  JTP_PRE_TMS_RST_N = 3'h6;
  localparam logic [5:0]  JTP_PRE_TRST     = 6'h00;  // 0 to idle
  localparam logic [2:0]  JTP_PRE_TRST_N   = 3'h1;
  localparam logic [5:0]  JTP_PRE_IR       = 6'h03;  // 1,1,0,0
  localparam logic [2:0]  JTP_PRE_IR_N     = 3'h4;
  localparam logic [5:0]  JTP_PRE_DR       = 6'h01;  // 1,0,0
  localparam logic [2:0]  JTP_PRE_DR_N     = 3'h3;
  localparam logic [1:0]  JTP_POST_TMS     = 2'h1;   // 1 update, 0 idle
  localparam logic [1:0]  JTP_POST_N       = 2'h2;

  // Widest shift the controller handles in one command
  localparam int          JTP_DW         = 32;
  localparam logic [5:0]  JTP_DW_LEN     = 6'h20;

endpackage

/* jtp_link_if.sv */
/*
  The four-wire test link plus optional test reset between controller
  and device. Resolves pull-ups: an undriven input line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
interface jtp_link_if;
  logic tck;        // Link clock, made by the controller
  logic tms_o;      // Mode select, controller drive value
  logic tms_oe;     // Mode select, controller drives
  logic tdi_o;      // Test data in, controller drive value
  logic tdi_oe;     // Test data in, controller drives
  logic trst_n_o;   // Test reset, controller drive value
  logic trst_n_oe;  // Test reset, controller drives
  logic tdo_o;      // Test data out, device drive value
  logic tdo_oe;     // Test data out, device drives
  logic tms;        // Resolved mode select
  logic tdi;        // Resolved test data in
  logic trst_n;     // Resolved test reset

  // Internal pull-ups on all three inputs
  assign tms    = tms_oe    ? tms_o    : 1'b1;
  assign tdi    = tdi_oe    ? tdi_o    : 1'b1;
  assign trst_n = trst_n_oe ? trst_n_o : 1'b1;

  modport device (input tck, input tms, input tdi, input trst_n,
                  output tdo_o, output tdo_oe);
  modport host   (output tck, output tms_o, output tms_oe,
                  output tdi_o, output tdi_oe, output trst_n_o,
                  output trst_n_oe, input tdo_o, input tdo_oe);
endinterface
`default_nettype wire

/* jtp_tap_port.sv */
/*
  Test access port of the device: controller, instruction, identity and
  bypass registers, with level status carried to the core clock.
  Assumes the link clock and pins arrive through jtp_link_if.
*/
// Operation
// - Rising test clock shifts data into selected register
// - Test data out changes on falling clock
// - Data out driven only in shift states
// - Mode select alone steers state transitions
// - Test reset clears controller without clock
// - No power-up reset; five high selects reset
// - Outputs stay undriven until properly reset
// - Spare test reset may tie to master reset
// - Unused scan: hold test reset low
// - Floating mode select reads high
// - Floating data in reads high
// - Inputs sampled on rising test clock
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_port (
  jtp_link_if.device link,              // Pins toward the controller
  input  wire logic  clk,               // Core clock
  input  wire logic  arst_n,            // Core reset, active low
  output logic       core_tap_in_reset, // Controller sits in reset state
  output logic       core_tap_ready     // Controller has been reset once
);

  // Controller state and its next value
  jtp_pkg::jtp_state_t state_reg;
  jtp_pkg::jtp_state_t state_next;
  // Run of consecutive high mode-select samples; known from power-up
  // so that five high clocks recover even an unknown state
  logic [2:0]          tms_run_reg = 3'h0;
  // Set once a proper reset has been seen; clear at power-up
  logic                reset_seen_reg = 1'b0;
  // Instruction shift stage and latched instruction
  logic [jtp_pkg::JTP_IR_W-1:0] ir_shift_reg;
  logic [jtp_pkg::JTP_IR_W-1:0] ir_reg;
  // Identification shift stage
  logic [jtp_pkg::JTP_ID_W-1:0] id_shift_reg;
  // Single bypass stage
  logic                bypass_reg;
  // Falling-edge output stages
  logic                tdo_reg;
  logic                tdo_oe_reg = 1'b0; // Undriven from power-up
  // Status in the link domain, flopped so the sync sees no glitch
  logic                tlr_flag_reg;
  // Two-stage synchronisers into the core clock
  logic                tlr_meta_reg;
  logic                ready_meta_reg;
  // Identity register chosen by current instruction
  logic                id_sel;
  // Fifth high mode-select sample forces the reset state
  logic                force_tlr;

  // Standard state walk; only mode select decides the branch
  function automatic jtp_pkg::jtp_state_t tap_step(
    input jtp_pkg::jtp_state_t s,
    input logic                m
  );
    jtp_pkg::jtp_state_t n;
    n = s;
    unique case (s)
      jtp_pkg::JTP_TLR:      n = m ? jtp_pkg::JTP_TLR    : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_RTI:      n = m ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_SEL_DR:   n = m ? jtp_pkg::JTP_SEL_IR
                                   : jtp_pkg::JTP_CAP_DR;
      jtp_pkg::JTP_CAP_DR:   n = m ? jtp_pkg::JTP_EX1_DR
                                   : jtp_pkg::JTP_SHIFT_DR;
      jtp_pkg::JTP_SHIFT_DR: n = m ? jtp_pkg::JTP_EX1_DR
                                   : jtp_pkg::JTP_SHIFT_DR;
      jtp_pkg::JTP_EX1_DR:   n = m ? jtp_pkg::JTP_UPD_DR
                                   : jtp_pkg::JTP_PAUSE_DR;
      jtp_pkg::JTP_PAUSE_DR: n = m ? jtp_pkg::JTP_EX2_DR
                                   : jtp_pkg::JTP_PAUSE_DR;
      jtp_pkg::JTP_EX2_DR:   n = m ? jtp_pkg::JTP_UPD_DR
                                   : jtp_pkg::JTP_SHIFT_DR;
      jtp_pkg::JTP_UPD_DR:   n = m ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_SEL_IR:   n = m ? jtp_pkg::JTP_TLR
                                   : jtp_pkg::JTP_CAP_IR;
      jtp_pkg::JTP_CAP_IR:   n = m ? jtp_pkg::JTP_EX1_IR
                                   : jtp_pkg::JTP_SHIFT_IR;
      jtp_pkg::JTP_SHIFT_IR: n = m ? jtp_pkg::JTP_EX1_IR
                                   : jtp_pkg::JTP_SHIFT_IR;
      jtp_pkg::JTP_EX1_IR:   n = m ? jtp_pkg::JTP_UPD_IR
                                   : jtp_pkg::JTP_PAUSE_IR;
      jtp_pkg::JTP_PAUSE_IR: n = m ? jtp_pkg::JTP_EX2_IR
                                   : jtp_pkg::JTP_PAUSE_IR;
      jtp_pkg::JTP_EX2_IR:   n = m ? jtp_pkg::JTP_UPD_IR
                                   : jtp_pkg::JTP_SHIFT_IR;
      jtp_pkg::JTP_UPD_IR:   n = m ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
    endcase
    return n;
  endfunction

  // Next state from the sampled mode select
  always_comb
  begin
    state_next = tap_step(state_reg, link.tms);
  end

  // Identity register in the data path only for its instruction
  assign id_sel = (ir_reg == jtp_pkg::JTP_INS_IDCODE);

  // Works even from an unknown state, where the normal walk cannot
  assign force_tlr = link.tms &&
                     (tms_run_reg == jtp_pkg::JTP_TMS_RESET_CNT - 3'h1);

  // Controller state; test reset acts with no clock at all
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      state_reg <= jtp_pkg::JTP_TLR;
    else if (force_tlr)
      state_reg <= jtp_pkg::JTP_TLR;
    else
      state_reg <= state_next;
  end

  // Count high mode-select clocks; saturates at the reset count
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      tms_run_reg <= 3'h0;
    else if (!link.tms)
      tms_run_reg <= 3'h0;
    else if (tms_run_reg != jtp_pkg::JTP_TMS_RESET_CNT)
      tms_run_reg <= tms_run_reg + 3'h1;
  end

  // Remember a proper reset. The controller state has no power-up
  // value, so only a reset unlocks the output driver.
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      reset_seen_reg <= 1'b1;
    else if (force_tlr || state_next == jtp_pkg::JTP_TLR)
      reset_seen_reg <= 1'b1;
  end

  // Instruction shift stage: capture pattern, then shift in data in
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      ir_shift_reg <= jtp_pkg::JTP_IR_CAPTURE;
    else if (state_reg == jtp_pkg::JTP_CAP_IR)
      ir_shift_reg <= jtp_pkg::JTP_IR_CAPTURE;
    else if (state_reg == jtp_pkg::JTP_SHIFT_IR)
      ir_shift_reg <= {link.tdi, ir_shift_reg[jtp_pkg::JTP_IR_W-1:1]};
  end

  // Latched instruction; reset state selects the identity register
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      ir_reg <= jtp_pkg::JTP_INS_IDCODE;
    else if (state_reg == jtp_pkg::JTP_TLR)
      ir_reg <= jtp_pkg::JTP_INS_IDCODE;
    else if (state_reg == jtp_pkg::JTP_UPD_IR)
      ir_reg <= ir_shift_reg;
  end

  // Identity register: load fixed value, then shift
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      id_shift_reg <= jtp_pkg::JTP_ID_VALUE;
    else if (state_reg == jtp_pkg::JTP_CAP_DR && id_sel)
      id_shift_reg <= jtp_pkg::JTP_ID_VALUE;
    else if (state_reg == jtp_pkg::JTP_SHIFT_DR && id_sel)
      id_shift_reg <= {link.tdi, id_shift_reg[jtp_pkg::JTP_ID_W-1:1]};
  end

  // Bypass: captures zero, then one bit of delay from in to out
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      bypass_reg <= 1'b0;
    else if (state_reg == jtp_pkg::JTP_CAP_DR && !id_sel)
      bypass_reg <= 1'b0;
    else if (state_reg == jtp_pkg::JTP_SHIFT_DR && !id_sel)
      bypass_reg <= link.tdi;
  end

  // Output stage on the falling edge, half a period of hold for the
  // controller, which samples on the next rising edge
  always_ff @(negedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      tdo_reg <= 1'b1;
    else if (state_reg == jtp_pkg::JTP_SHIFT_IR)
      tdo_reg <= ir_shift_reg[0];
    else if (state_reg == jtp_pkg::JTP_SHIFT_DR)
      tdo_reg <= id_sel ? id_shift_reg[0] : bypass_reg;
  end

  // Output enable: only while shifting, and only after a reset
  always_ff @(negedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      tdo_oe_reg <= 1'b0;
    else
      tdo_oe_reg <= reset_seen_reg &&
                    (state_reg == jtp_pkg::JTP_SHIFT_IR ||
                     state_reg == jtp_pkg::JTP_SHIFT_DR);
  end

  assign link.tdo_o  = tdo_reg;
  assign link.tdo_oe = tdo_oe_reg;

  // Reset-state flag kept in a flop of the link domain
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
      tlr_flag_reg <= 1'b1;
    else
      tlr_flag_reg <= force_tlr || (state_next == jtp_pkg::JTP_TLR);
  end

  // Level synchronisers into the core clock. The link clock may stop
  // between frames; these are levels, so a stopped clock is harmless.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tlr_meta_reg      <= 1'b0;
      core_tap_in_reset <= 1'b0;
    end
    else
    begin
      tlr_meta_reg      <= tlr_flag_reg;
      core_tap_in_reset <= tlr_meta_reg;
    end
  end

  // Ready flag synchroniser
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_meta_reg <= 1'b0;
      core_tap_ready <= 1'b0;
    end
    else
    begin
      ready_meta_reg <= reset_seen_reg;
      core_tap_ready <= ready_meta_reg;
    end
  end

endmodule
`default_nettype wire

/* jtp_tap_ctrl.sv */
/*
  Boundary-scan controller end: makes the link clock from clk by a
  divider and walks the device through resets and shifts on command.
  Assumes jtp_link_if carries the pins; user side is valid/ready.
*/
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_ctrl (
  jtp_link_if.host        link,        // Pins toward the device
  input  wire logic       clk,         // System clock, 40 MHz
  input  wire logic       arst_n,      // Reset, active low
  input  wire logic       cmd_valid,   // Command offered
  input  wire logic [1:0] cmd_kind,    // Command code
  input  wire logic [5:0] cmd_len,     // Shift length, 1 to 32
  input  wire logic [31:0] cmd_data,   // Data to shift, LSB first
  output logic            cmd_ready,   // Idle, command taken
  output logic            rsp_valid,   // One-cycle result pulse
  output logic [31:0]     rsp_data     // Captured data, right aligned
);

  // Sequencer phases
  typedef enum logic [1:0] {
    JTP_H_IDLE = 2'h0,
    JTP_H_TRST = 2'h1,
    JTP_H_RUN  = 2'h2
  } jtp_phase_t;

  jtp_phase_t  phase_reg;     // Current phase
  logic [3:0]  div_reg;       // Half-period divider
  logic        tck_reg;       // Link clock out
  logic        go_reg;        // Emit first bit of a walk
  logic [5:0]  pre_reg;       // Mode-select bits before the shift
  logic [2:0]  pre_cnt_reg;   // Bits left in pre
  logic [5:0]  sh_cnt_reg;    // Shift bits left
  logic [5:0]  len_reg;       // Shift length of the command
  logic [1:0]  post_reg;      // Mode-select bits after the shift
  logic [1:0]  post_cnt_reg;  // Bits left in post
  logic [31:0] dout_reg;      // Outgoing data
  logic [31:0] din_reg;       // Incoming data
  logic        shifting_reg;  // Current bit is a data bit
  logic        tms_reg;       // Mode select drive
  logic        tdi_reg;       // Data in drive
  logic        trst_n_reg;    // Test reset drive
  logic [3:0]  trst_cnt_reg;  // Test reset hold count
  logic [1:0]  tdo_meta_reg;  // First sync stage: data, enable
  logic [1:0]  tdo_sync_reg;  // Second sync stage
  logic        tick;          // Half period elapsed
  logic        rise;          // Link clock about to rise
  logic        fall;          // Link clock about to fall
  logic        advance;       // Put next bit on the pins
  logic        walk_done;     // No bits left after this fall

  assign tick = (phase_reg == JTP_H_RUN) && !go_reg &&
                (div_reg == jtp_pkg::JTP_TCK_HALF_CYC - 4'h1);
  assign rise = tick && !tck_reg;
  assign fall = tick && tck_reg;
  assign advance = go_reg || fall;
  assign walk_done = (pre_cnt_reg == 3'h0) && (sh_cnt_reg == 6'h00) &&
                     (post_cnt_reg == 2'h0);

  // Divider and link clock; clock rests low outside walks
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_reg <= 4'h0;
      tck_reg <= 1'b0;
    end
    else if (phase_reg != JTP_H_RUN || go_reg)
    begin
      div_reg <= 4'h0;
      tck_reg <= 1'b0;
    end
    else if (tick)
    begin
      div_reg <= 4'h0;
      tck_reg <= !tck_reg;
    end
    else
      div_reg <= div_reg + 4'h1;
  end

  // Data out from the device, two stages before use
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tdo_meta_reg <= 2'h0;
      tdo_sync_reg <= 2'h0;
    end
    else
    begin
      tdo_meta_reg <= {link.tdo_oe, link.tdo_o};
      tdo_sync_reg <= tdo_meta_reg;
    end
  end

  // Phase control, command take-in and the walk itself
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_reg    <= JTP_H_IDLE;
      go_reg       <= 1'b0;
      pre_reg      <= 6'h00;
      pre_cnt_reg  <= 3'h0;
      sh_cnt_reg   <= 6'h00;
      len_reg      <= 6'h00;
      post_reg     <= 2'h0;
      post_cnt_reg <= 2'h0;
      dout_reg     <= 32'h0000_0000;
      shifting_reg <= 1'b0;
      tms_reg      <= 1'b1;
      tdi_reg      <= 1'b1;
      trst_n_reg   <= 1'b1;
      trst_cnt_reg <= 4'h0;
    end
    else
    begin
      go_reg <= 1'b0;
      unique case (phase_reg)
        JTP_H_IDLE:
        begin
          if (cmd_valid)
          begin
            dout_reg     <= cmd_data;
            len_reg      <= 6'h00;
            sh_cnt_reg   <= 6'h00;
            post_cnt_reg <= 2'h0;
            post_reg     <= jtp_pkg::JTP_POST_TMS;
            unique case (jtp_pkg::jtp_cmd_t'(cmd_kind))
              jtp_pkg::JTP_CMD_TMS_RESET:
              begin
                pre_reg     <= jtp_pkg::JTP_PRE_TMS_RST;
                pre_cnt_reg <= jtp_pkg::JTP_PRE_TMS_RST_N;
                phase_reg   <= JTP_H_RUN;
                go_reg      <= 1'b1;
              end
              jtp_pkg::JTP_CMD_TRST_RESET:
              begin
                pre_reg      <= jtp_pkg::JTP_PRE_TRST;
                pre_cnt_reg  <= jtp_pkg::JTP_PRE_TRST_N;
                trst_n_reg   <= 1'b0;
                trst_cnt_reg <= 4'h0;
                phase_reg    <= JTP_H_TRST;
              end
              jtp_pkg::JTP_CMD_SHIFT_IR,
              jtp_pkg::JTP_CMD_SHIFT_DR:
              begin
                pre_reg      <= (cmd_kind == 2'(jtp_pkg::JTP_CMD_SHIFT_IR))
                                ? jtp_pkg::JTP_PRE_IR : jtp_pkg::JTP_PRE_DR;
                pre_cnt_reg  <= (cmd_kind == 2'(jtp_pkg::JTP_CMD_SHIFT_IR))
                                ? jtp_pkg::JTP_PRE_IR_N
                                : jtp_pkg::JTP_PRE_DR_N;
                len_reg      <= cmd_len;
                sh_cnt_reg   <= cmd_len;
                post_cnt_reg <= jtp_pkg::JTP_POST_N;
                phase_reg    <= JTP_H_RUN;
                go_reg       <= 1'b1;
              end
            endcase
          end
        end
        JTP_H_TRST:
        begin
          // Hold test reset low long enough, then walk to idle
          if (trst_cnt_reg == jtp_pkg::JTP_TRST_CYC - 4'h1)
          begin
            trst_n_reg <= 1'b1;
            phase_reg  <= JTP_H_RUN;
            go_reg     <= 1'b1;
          end
          else
            trst_cnt_reg <= trst_cnt_reg + 4'h1;
        end
        JTP_H_RUN:
        begin
          // New bits go out while the clock is low
          if (advance)
          begin
            if (pre_cnt_reg != 3'h0)
            begin
              tms_reg     <= pre_reg[0];
              pre_reg     <= {1'b0, pre_reg[5:1]};
              pre_cnt_reg <= pre_cnt_reg - 3'h1;
            end
            else if (sh_cnt_reg != 6'h00)
            begin
              tms_reg      <= (sh_cnt_reg == 6'h01);
              tdi_reg      <= dout_reg[0];
              dout_reg     <= {1'b0, dout_reg[31:1]};
              sh_cnt_reg   <= sh_cnt_reg - 6'h01;
              shifting_reg <= 1'b1;
            end
            else if (post_cnt_reg != 2'h0)
            begin
              tms_reg      <= post_reg[0];
              post_reg     <= {1'b0, post_reg[1]};
              post_cnt_reg <= post_cnt_reg - 2'h1;
              shifting_reg <= 1'b0;
            end
            else
            begin
              shifting_reg <= 1'b0;
              phase_reg    <= JTP_H_IDLE;
            end
          end
        end
        default:
          phase_reg <= JTP_H_IDLE;
      endcase
    end
  end

  // Capture data out just before each rising edge of a data bit;
  // the device changed it half a period earlier, so it has settled
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      din_reg <= 32'h0000_0000;
    else if (phase_reg == JTP_H_IDLE && cmd_valid)
      din_reg <= 32'h0000_0000;
    else if (rise && shifting_reg)
      // Undriven data out is read as high
      din_reg <= {tdo_sync_reg[1] ? tdo_sync_reg[0] : 1'b1, din_reg[31:1]};
  end

  // Result pulse when a walk ends, data right aligned
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid <= fall && walk_done;
      if (fall && walk_done)
        rsp_data <= din_reg >> (jtp_pkg::JTP_DW_LEN - len_reg);
    end
  end

  // Ready only while idle and not taking a command this cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cmd_ready <= 1'b0;
    else
      cmd_ready <= (phase_reg == JTP_H_IDLE) && !cmd_valid &&
                   !(fall && walk_done);
  end

  assign link.tck       = tck_reg;
  assign link.tms_o     = tms_reg;
  assign link.tms_oe    = 1'b1;
  assign link.tdi_o     = tdi_reg;
  assign link.tdi_oe    = 1'b1;
  assign link.trst_n_o  = trst_n_reg;
  assign link.trst_n_oe = 1'b1;

endmodule
`default_nettype wire

/* jtp_tap_port_asserts.sv */
/* Pin checker for the test link.
   Assumes the bench wires it to the link. */
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_port_asserts (
  input wire logic tck,    // Link clock
  input wire logic tms,    // Mode select
  input wire logic trst_n, // Test reset
  input wire logic tdo_o,  // Data out
  input wire logic tdo_oe  // Data out driven
);
  // Pins seen at rising tck, quiet in test reset
  default clocking cb @(posedge tck);
  endclocking
  default disable iff (!trst_n);
  // Forced reset, idle, then into Shift-DR
  sequence to_dr;
    tms[*5] ##1 !tms ##1 tms ##1 !tms[*2];
  endsequence
  // Same, but into Shift-IR
  sequence to_ir;
    tms[*5] ##1 !tms ##1 tms[*2] ##1 !tms[*2];
  endsequence
  a_tms_five_reset: assert property (tms[*5] |=> !tdo_oe)
    else $error("five high tms left tdo driven");
  // High at the first rising tck after a test reset
  logic fresh_reg;
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      fresh_reg <= 1'b1;
    else
      fresh_reg <= 1'b0;
  end
  a_trst_quiet: assert property (fresh_reg |-> !tdo_oe)
    else $error("tdo driven after test reset");
  a_oe_rise_cause: assert property ($rose(tdo_oe) |-> !$past(tms))
    else $error("shift entered without low tms");
  a_oe_hold_shift: assert property (tdo_oe && !tms |=> tdo_oe)
    else $error("tdo released inside shift");
  a_oe_leave_shift: assert property (tdo_oe && tms |=> !tdo_oe)
    else $error("tdo still driven after shift");
  a_ir_first_bit: assert property (to_ir |=> tdo_oe && tdo_o)
    else $error("ir capture bit wrong");
  a_dr_first_bit: assert property (to_dr |=>
    tdo_oe && tdo_o == jtp_pkg::JTP_ID_VALUE[0])
    else $error("id first bit wrong");
  a_dr_next_bit: assert property (to_dr ##1 !tms |=>
    tdo_o == jtp_pkg::JTP_ID_VALUE[1])
    else $error("id second bit wrong");
  cover property (to_dr);
  cover property (to_ir);
  cover property (tms[*5]);
endmodule
`default_nettype wire

/* jtp_tap_port_bench.sv */
/* Bench: controller and port joined by the link.
   Assumes a 40 MHz clk; the link clock is divided. */
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_port_bench;
  typedef struct packed {
    logic [1:0]  k; // Command
    logic [5:0]  l; // Length
    logic [31:0] d; // Data out
    logic [31:0] e; // Expected reply
  } jtp_row_t;
  logic        clk;
  logic        arst_n;
  logic        cmd_valid;
  logic [1:0]  cmd_kind;
  logic [5:0]  cmd_len;
  logic [31:0] cmd_data;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic        core_tap_in_reset;
  logic        core_tap_ready;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  // Replies right aligned: first bit out lands in bit 0
  jtp_row_t    rows [7] = '{
    '{2'h0, 6'h00, 32'h0, 32'h0},
    '{2'h2, 6'h04, 32'h1, {28'h0, jtp_pkg::JTP_IR_CAPTURE}},
    '{2'h3, 6'h20, 32'h0, jtp_pkg::JTP_ID_VALUE},
    '{2'h2, 6'h04, 32'hF, {28'h0, jtp_pkg::JTP_IR_CAPTURE}},
    '{2'h3, 6'h08, 32'hA5, 32'h0000_004A}, // Bypass: 0, then A5 late
    '{2'h1, 6'h00, 32'h0, 32'h0}, // Test reset pulse
    '{2'h3, 6'h01, 32'h0, {31'h0, jtp_pkg::JTP_ID_VALUE[0]}}};
  jtp_link_if link ();
  jtp_tap_ctrl jtp_tap_ctrl_i (.link(link), .clk, .arst_n, .cmd_valid,
    .cmd_kind, .cmd_len, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data);
  jtp_tap_port jtp_tap_port_i (.link(link), .clk, .arst_n,
    .core_tap_in_reset, .core_tap_ready);
  jtp_tap_port_asserts jtp_tap_port_asserts_i (.tck(link.tck),
    .tms(link.tms), .trst_n(link.trst_n), .tdo_o(link.tdo_o),
    .tdo_oe(link.tdo_oe));
  always #12.5 clk = ~clk;
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Wait for ready, offer the command for one edge, then wait for
  // the reply pulse
  task automatic run(input logic [1:0] k, input logic [5:0] l,
                     input logic [31:0] d);
    int n;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++)
      @(posedge clk) #2;
    cmd_kind = k;
    cmd_len = l;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk) #2;
    cmd_valid = 1'b0;
    for (n = 0; n < 400 && rsp_valid !== 1'b1; n++)
      @(posedge clk) #2;
    chk({31'h0, rsp_valid}, 32'h1);
  endtask
  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_len = 6'h00;
    cmd_data = 32'h0;
    repeat (2) @(posedge clk) #2;
    chk({31'h0, link.tdo_oe}, 32'h0);
    chk({31'h0, core_tap_ready}, 32'h0);
    arst_n = 1'b1;
    repeat (2) @(posedge clk) #2;
    foreach (rows[i])
    begin
      run(rows[i].k, rows[i].l, rows[i].d);
      if (rows[i].k[1])
        chk(rsp_data, rows[i].e);
      else
        chk({30'h0, core_tap_ready, core_tap_in_reset}, 32'h2);
    end
    // Bypass loaded, then a mode-select reset must bring back the id
    run(2'h2, 6'h04, 32'hF);
    run(2'h0, 6'h00, 32'h0);
    run(2'h3, 6'h20, 32'h0);
    chk(rsp_data, jtp_pkg::JTP_ID_VALUE);
    give_verdict();
  end
endmodule
`default_nettype wire
